// [design/rsc_pkg.sv]
// Constants for the reset source combiner: register map, bit positions
// and reset values. Assumes nothing of its users beyond explicit
// rsc_pkg:: references.
package rsc_pkg;

  // Register map, word addresses on the Avalon-MM slave
  localparam logic [1:0]  RCC_ADDR          = 2'h0;   // reset_cause_control
  localparam int          RCC_WIDTH         = 16;

  // Bit positions inside reset_cause_control
  localparam int          POWER_ON_BIT      = 0;
  localparam int          BROWNOUT_BIT      = 1;
  localparam int          IDLE_WAKE_BIT     = 2;
  localparam int          SLEEP_WAKE_BIT    = 3;
  localparam int          WDT_TIMEOUT_BIT   = 4;
  localparam int          WDT_SOFT_EN_BIT   = 5;
  localparam int          SOFT_RESET_BIT    = 6;
  localparam int          PIN_RESET_BIT     = 7;
  localparam int          REG_SLEEP_BIT     = 8;
  localparam int          CFG_MISMATCH_BIT  = 9;
  localparam int          ILLEGAL_COND_BIT  = 14;
  localparam int          TRAP_CONFLICT_BIT = 15;

  // Variant option: configuration mismatch source and flag present
  localparam logic        CM_PRESENT        = 1'b1;

  // Implemented bits; bits 13..10 are absent, bit 9 follows the variant
  localparam logic [15:0] RCC_IMPL_MASK     = CM_PRESENT ? 16'hc3ff : 16'hc1ff;

  // Value after power-on reset: power-on and brown-out flags set
  localparam logic [15:0] RCC_POR_VALUE     = 16'h0003;

  // Synchroniser reset values for the pin inputs {fuse, clear_n, brownout}
  localparam logic [2:0]  PIN_SYNC_RESET    = 3'h2;

endpackage : rsc_pkg

// [design/rsc_sync.sv]
// Two-flop synchroniser for levels that arrive from pins.
// Assumes the levels are quasi-static compared with the 100 ns clock.
`timescale 1ns/100ps
module rsc_sync #(
  parameter int          WIDTH     = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and control
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             ce,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage is read only by the second stage
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else if (ce) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : rsc_sync

// [design/rsc_flag.sv]
// One bit of the reset cause register: hardware set, software write.
// Assumes the caller gates hw_set and sw_we with nothing but its own logic.
`timescale 1ns/100ps
module rsc_flag #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and control
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic ce,
  // Set and write
  input  wire logic hw_set,
  input  wire logic sw_we,
  input  wire logic sw_wdata,
  // State
  output logic      flag_q
);

  logic flag_d;

  // A hardware event outranks a software clear in the same cycle
  always_comb begin
    flag_d = sw_we ? sw_wdata : flag_q;
    if (hw_set) begin
      flag_d = 1'b1;
    end
  end

  // Only power-on reset touches the bit; warm resets leave it alone
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flag_q <= RST_VAL;
    end else if (ce) begin
      flag_q <= flag_d;
    end
  end

endmodule : rsc_flag

// [design/rsc_top.sv]
// Reset source combiner: ORs all reset sources into the master system
// reset and keeps the reset cause register on an Avalon-MM slave.
// Assumes rst_n is the power-on reset, the core-side sources are on this
// clock, and brown-out, clear pin and the watchdog fuse come from pins.
//
// Function
// - Any active source drives master reset
// - Opcode, uninit register, security share one flag
// - Each reset kind sets its own flag
// - Power-on leaves register at 0x0003
// - Software sets/clears flags, never causes reset
// - Bits 13..10 read zero, ignore writes
// - Bit 15 set on trap conflict reset
// - Bit 14 set on illegal condition reset
// - Bit 9 set on config mismatch, optional
// - Bit 8 keeps regulator active in Sleep
// - Bit 7 set on clear pin reset
// - Bit 6 set on reset instruction
// - Fuse one forces watchdog always enabled
// - Bit 4 set on watchdog time-out
// - Bit 3 shows device was in Sleep
// - Bit 2 shows device was in Idle
// - Bit 1 set on brown-out reset
// - Bit 0 set on power-on reset
// - Power-on and brown-out are cold resets
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
module rsc_top (
  // Clock, reset, enable
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Avalon-MM slave
  input  wire logic [1:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Pin sources, asynchronous
  input  wire logic        brownout_in,
  input  wire logic        external_clear_pin_n,
  input  wire logic        watchdog_fuse_enable,
  // Core-side sources, on this clock
  input  wire logic        soft_reset_req,
  input  wire logic        watchdog_timeout,
  input  wire logic        config_mismatch,
  input  wire logic        trap_conflict,
  input  wire logic        illegal_opcode,
  input  wire logic        uninit_wreg_access,
  input  wire logic        security_violation,
  input  wire logic        sleep_wake,
  input  wire logic        idle_wake,
  // Reset and control outputs
  output logic             master_system_reset,
  output logic             reset_is_cold,
  output logic             watchdog_enable,
  output logic             regulator_sleep_active
);

  logic [2:0]  pins_s;
  logic        brownout_s;
  logic        clear_pin_n_s;
  logic        fuse_s;
  logic        illegal_any;
  logic        src_any;
  logic        cold_src;
  logic [15:0] hw_set;
  logic [15:0] sw_we;
  logic [15:0] flags_q;
  logic [15:0] rcc_view;
  logic        wr_acc;
  logic        rd_hit;

  // Pin levels are synchronised before any logic looks at them
  rsc_sync #(
    .WIDTH   (3),
    .RST_VAL (rsc_pkg::PIN_SYNC_RESET)
  ) u_pin_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .ce       (ce),
    .async_in ({watchdog_fuse_enable, external_clear_pin_n, brownout_in}),
    .sync_out (pins_s)
  );

  assign brownout_s    = pins_s[0];
  assign clear_pin_n_s = pins_s[1];
  assign fuse_s        = pins_s[2];

  // Three illegal conditions fold into one source
  assign illegal_any = illegal_opcode | uninit_wreg_access | security_violation;

  // Every reset source, ORed, wake events left out; mismatch only counts on variants that have it
  assign src_any = brownout_s | ~clear_pin_n_s | soft_reset_req | watchdog_timeout
                 | (config_mismatch & rsc_pkg::CM_PRESENT)
                 | trap_conflict | illegal_any;

  // Cold sources are power-on and brown-out only
  assign cold_src = brownout_s;

  // Hardware set vector, one dedicated bit per reset kind
  always_comb begin
    hw_set = 16'h0000;
    hw_set[rsc_pkg::TRAP_CONFLICT_BIT] = trap_conflict;
    hw_set[rsc_pkg::ILLEGAL_COND_BIT]  = illegal_any;
    hw_set[rsc_pkg::CFG_MISMATCH_BIT]  = config_mismatch & rsc_pkg::CM_PRESENT;
    hw_set[rsc_pkg::PIN_RESET_BIT]     = ~clear_pin_n_s;
    hw_set[rsc_pkg::SOFT_RESET_BIT]    = soft_reset_req;
    hw_set[rsc_pkg::WDT_TIMEOUT_BIT]   = watchdog_timeout;
    hw_set[rsc_pkg::SLEEP_WAKE_BIT]    = sleep_wake;
    hw_set[rsc_pkg::IDLE_WAKE_BIT]     = idle_wake;
    hw_set[rsc_pkg::BROWNOUT_BIT]      = brownout_s;
    hw_set[rsc_pkg::POWER_ON_BIT]      = 1'b0; // Set by the reset value
  end

  // Write takes effect at the edge where the master sees waitrequest low
  assign wr_acc = ce & write & ~waitrequest & (address == rsc_pkg::RCC_ADDR);
  assign rd_hit = read & (address == rsc_pkg::RCC_ADDR);

  // Per-bit write strobe; low byte on lane 0, high byte on lane 1
  always_comb begin
    sw_we = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      sw_we[i] = wr_acc & byteenable[i / 8];
    end
  end

  // One flag per bit; absent bits are constant zero and drop writes
  genvar g;
  generate
    for (g = 0; g < rsc_pkg::RCC_WIDTH; g++) begin : g_bit
      if (rsc_pkg::RCC_IMPL_MASK[g]) begin : g_impl
        rsc_flag #(
          .RST_VAL (rsc_pkg::RCC_POR_VALUE[g])
        ) u_flag (
          .clock    (clock),
          .rst_n    (rst_n),
          .ce       (ce),
          .hw_set   (hw_set[g]),
          .sw_we    (sw_we[g]),
          .sw_wdata (writedata[g]),
          .flag_q   (flags_q[g])
        );
      end else begin : g_none
        assign flags_q[g] = 1'b0;
      end
    end
  endgenerate

  assign rcc_view = flags_q & rsc_pkg::RCC_IMPL_MASK;

  // Bus handshake: one wait cycle, then one cycle with waitrequest low.
  // Read data is captured in the wait cycle, so a flag set in the very
  // cycle of acceptance shows on the next read.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else if (ce) begin
      waitrequest <= ~(waitrequest & (read | write));
    end
  end

  // Read data; unmapped words read zero, upper half always zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (ce && waitrequest) begin
      readdata <= rd_hit ? {16'h0000, rcc_view} : 32'h0000_0000;
    end
  end

  // Master reset follows the OR of sources; held during power-on reset.
  // A software write only stores bits and never reaches this term.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      master_system_reset <= 1'b1;
      reset_is_cold       <= 1'b1;
    end else if (ce) begin
      master_system_reset <= src_any;
      reset_is_cold       <= cold_src;
    end
  end

  // Watchdog enable: an unprogrammed fuse overrides the soft bit
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      watchdog_enable <= 1'b0;
    end else if (ce) begin
      watchdog_enable <= fuse_s | flags_q[rsc_pkg::WDT_SOFT_EN_BIT];
    end
  end

  // Regulator stays active in Sleep while the bit is one
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      regulator_sleep_active <= 1'b0;
    end else if (ce) begin
      regulator_sleep_active <= flags_q[rsc_pkg::REG_SLEEP_BIT];
    end
  end

  // Checks on the logic above
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_req_seen;
    ce && (read || write) && waitrequest;
  endsequence

  sequence s_req_done;
    ce && !waitrequest;
  endsequence

  bus_handshake_a: assert property (s_req_seen ##1 ce |-> !waitrequest ##1 waitrequest)
    else $error("waitrequest did not drop for exactly one cycle");

  master_or_a: assert property (ce && src_any |=> master_system_reset)
    else $error("master reset missed an active source");

  illegal_share_a: assert property (ce && (illegal_opcode || uninit_wreg_access
      || security_violation) |=> flags_q[14])
    else $error("illegal condition flag not set");

  por_value_a: assert property ($rose(rst_n) |-> flags_q == rsc_pkg::RCC_POR_VALUE)
    else $error("power-on value of cause register wrong");

  soft_no_reset_a: assert property (s_req_done and (write && !src_any)
      |=> !master_system_reset)
    else $error("software write caused a master reset");

  unimpl_zero_a: assert property (flags_q[13:10] == 4'h0 && readdata[31:16] == 16'h0000
      && readdata[13:10] == 4'h0)
    else $error("unimplemented bits not zero");

  trap_flag_a: assert property (ce && trap_conflict |=> flags_q[15] && master_system_reset)
    else $error("trap conflict flag or reset missing");

  hw_wins_a: assert property (ce |=> (flags_q & $past(hw_set)) == $past(hw_set))
    else $error("hardware set lost against software write");

  warm_keep_a: assert property (ce && !wr_acc |=> flags_q == ($past(flags_q) | $past(hw_set)))
    else $error("flag changed without cause");

  wdt_fuse_a: assert property (ce && fuse_s |=> watchdog_enable)
    else $error("fuse did not force watchdog enable");

  wdt_soft_a: assert property (ce && !fuse_s |=> watchdog_enable == $past(flags_q[5]))
    else $error("watchdog enable does not follow soft bit");

  cold_class_a: assert property (ce |=> reset_is_cold == $past(brownout_s))
    else $error("cold reset classification wrong");

  // Bus steps: a taken read captures the register, completion re-arms the wait
  sequence s_read_hit;
    ce && read && waitrequest && rd_hit;
  endsequence

  sequence s_read_miss;
    ce && read && waitrequest && !rd_hit;
  endsequence

  read_data_a: assert property (s_read_hit |=> readdata == {16'h0000, $past(rcc_view)})
    else $error("read data does not match the register");

  read_miss_a: assert property (s_read_miss |=> readdata == 32'h0000_0000)
    else $error("unmapped read returned nonzero data");

  bus_rearm_a: assert property (s_req_done |=> waitrequest)
    else $error("waitrequest did not return high after completion");

  // Software writes land per lane; a hardware set in that cycle still wins
  low_lane_a: assert property (wr_acc && byteenable[0]
      |=> flags_q[7:0] == ($past(writedata[7:0]) | $past(hw_set[7:0])))
    else $error("low byte write did not land");

  high_lane_a: assert property (wr_acc && byteenable[1]
      |=> flags_q[15:8] == (($past(writedata[15:8]) | $past(hw_set[15:8])) & 8'hc3))
    else $error("high byte write did not land");

  lane_keep_a: assert property (wr_acc && !byteenable[1]
      |=> flags_q[15:8] == ($past(flags_q[15:8]) | $past(hw_set[15:8])))
    else $error("disabled lane changed the register");

  // Each reset kind reaches its own flag; all but config mismatch are also checked on the master reset
  pin_flag_a: assert property (ce && !clear_pin_n_s |=> flags_q[7] && master_system_reset)
    else $error("clear pin flag or reset missing");

  soft_flag_a: assert property (ce && soft_reset_req |=> flags_q[6] && master_system_reset)
    else $error("reset instruction flag or reset missing");

  wdt_flag_a: assert property (ce && watchdog_timeout |=> flags_q[4] && master_system_reset)
    else $error("watchdog time-out flag or reset missing");

  cm_flag_a: assert property (ce && config_mismatch
      |=> flags_q[rsc_pkg::CFG_MISMATCH_BIT] == rsc_pkg::CM_PRESENT)
    else $error("config mismatch flag wrong");

  bor_flag_a: assert property (ce && brownout_s
      |=> flags_q[1] && master_system_reset && reset_is_cold)
    else $error("brown-out flag, reset or cold class missing");

  // Wake flags are status only and come from the power logic
  sleep_flag_a: assert property (ce && sleep_wake |=> flags_q[3])
    else $error("sleep wake flag not set");

  idle_flag_a: assert property (ce && idle_wake |=> flags_q[2])
    else $error("idle wake flag not set");

  // A flag only moves when its own source or software touches it
  illegal_only_a: assert property (ce && !illegal_any && !wr_acc
      |=> flags_q[14] == $past(flags_q[14]))
    else $error("illegal condition flag moved without cause");

  trap_only_a: assert property (ce && !trap_conflict && !wr_acc
      |=> flags_q[15] == $past(flags_q[15]))
    else $error("trap conflict flag moved without cause");

  // Master reset falls once no source is left; warm sources are not cold
  master_drop_a: assert property (ce && !src_any |=> !master_system_reset)
    else $error("master reset held with no source");

  warm_class_a: assert property (ce && src_any && !brownout_s |=> !reset_is_cold)
    else $error("warm reset shown as cold");

  reg_sleep_a: assert property (ce |=> regulator_sleep_active == $past(flags_q[8]))
    else $error("regulator control does not follow bit 8");

  // With the enable low nothing may move, or a stalled core loses events
  freeze_a: assert property (!ce |=> $stable(flags_q) && $stable(master_system_reset)
      && $stable(waitrequest))
    else $error("state changed while clock enable was low");

endmodule : rsc_top

// [tb/rsc_src_model.sv]
// Model of the reset sources and core logic facing the combiner.
// Assumes the bench moves sel and level just after a rising edge.
`timescale 1ns/100ps
module rsc_src_model (
  // Which source, and whether it is active
  input  wire logic [3:0] sel,
  input  wire logic       level,
  // Core-side sources
  output logic            soft_reset_req,
  output logic            watchdog_timeout,
  output logic            config_mismatch,
  output logic            trap_conflict,
  output logic            illegal_opcode,
  output logic            uninit_wreg_access,
  output logic            security_violation,
  output logic            sleep_wake,
  output logic            idle_wake,
  // Pin sources
  output logic            brownout_in,
  output logic            external_clear_pin_n
);
  // One source at a time, so every flag can be traced to one cause
  assign soft_reset_req       = level && sel == 4'h0;
  assign watchdog_timeout     = level && sel == 4'h1;
  assign config_mismatch      = level && sel == 4'h2;
  assign trap_conflict        = level && sel == 4'h3;
  // Three illegal conditions share one flag in the device
  assign illegal_opcode       = level && sel == 4'h4;
  assign uninit_wreg_access   = level && sel == 4'h5;
  assign security_violation   = level && sel == 4'h6;
  assign sleep_wake           = level && sel == 4'h7;
  assign idle_wake            = level && sel == 4'h8;
  // Pins idle at their quiet levels; the clear pin is active low
  assign brownout_in          = level && sel == 4'h9;
  assign external_clear_pin_n = !(level && sel == 4'ha);
endmodule : rsc_src_model

// [tb/testbench.sv]
// Self-checking bench for the reset source combiner: register model,
// source pulses and Avalon accesses. Assumes rsc_top and rsc_src_model.
`timescale 1ns/100ps
module testbench;
  // Clock, reset and bus
  logic        clock, rst_n = 1'b0, ce = 1'b1, read = 1'b0, write = 1'b0;
  logic [1:0]  address = 2'h0;
  logic [3:0]  byteenable = 4'h3, sel = 4'h0;
  logic [31:0] writedata = 32'h0, readdata;
  logic        waitrequest, level = 1'b0, watchdog_fuse_enable = 1'b0;
  // Sources and outputs
  logic        soft_reset_req, watchdog_timeout, config_mismatch, trap_conflict;
  logic        illegal_opcode, uninit_wreg_access, security_violation, sleep_wake;
  logic        idle_wake, brownout_in, external_clear_pin_n, master_system_reset;
  logic        reset_is_cold, watchdog_enable, regulator_sleep_active;
  // Bench state
  int          err_total = 0, checks = 0, rst_cnt = 0, cold_cnt = 0, k, r1;
  logic [15:0] exp_q, got;
  int          bitpos[11] = '{6, 4, 9, 15, 14, 14, 14, 3, 2, 1, 7};

  // Design and source model
  rsc_top DUT (.clock, .rst_n, .ce, .address, .read, .write, .byteenable, .writedata,
    .readdata, .waitrequest, .brownout_in, .external_clear_pin_n, .watchdog_fuse_enable,
    .soft_reset_req, .watchdog_timeout, .config_mismatch, .trap_conflict, .illegal_opcode,
    .uninit_wreg_access, .security_violation, .sleep_wake, .idle_wake, .master_system_reset,
    .reset_is_cold, .watchdog_enable, .regulator_sleep_active);
  rsc_src_model SRC (.sel, .level, .soft_reset_req, .watchdog_timeout, .config_mismatch,
    .trap_conflict, .illegal_opcode, .uninit_wreg_access, .security_violation,
    .sleep_wake, .idle_wake, .brownout_in, .external_clear_pin_n);

  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Count reset cycles, so a scenario sees whether a reset happened
  always @(posedge clock) begin
    if (master_system_reset === 1'b1) rst_cnt++;
    if (reset_is_cold === 1'b1) cold_cnt++;
  end

  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    checks++;
    if (got_v !== exp_v) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask : chk

  // One transfer; the request stands until waitrequest is seen low
  task automatic bus(input logic wr, input logic [1:0] a, input logic [15:0] d);
    int n;
    @(posedge clock);
    address   <= a;
    read      <= ~wr;
    write     <= wr;
    writedata <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      err_total++;
      conclude();
    end
    got = readdata[15:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  // One-cycle source pulse, then time for pin syncs and the flag to land
  task automatic pulse(input int s);
    @(posedge clock);
    sel   <= s[3:0];
    level <= 1'b1;
    @(posedge clock);
    level <= 1'b0;
    repeat (6) @(posedge clock);
  endtask : pulse

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  // A hang is cut short well after the few hundred cycles needed
  initial begin
    #(100 * 3000);
    err_total++;
    conclude();
  end

  initial begin
    r1 = $urandom(99);
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    // Power-on state
    bus(1'b0, 2'h0, 16'h0000);
    chk(got, 16'h0003);
    chk(cold_cnt > 0, 1'b1);
    chk({watchdog_enable, regulator_sleep_active}, 2'b00);
    // All ones written: only implemented bits stick, and no reset follows
    k = rst_cnt;
    bus(1'b1, 2'h0, 16'hffff);
    bus(1'b0, 2'h0, 16'h0000);
    chk(got, 16'hc3ff);
    chk(rst_cnt, k);
    chk({watchdog_enable, regulator_sleep_active}, 2'b11);
    // Unmapped address reads zero and its write is dropped
    bus(1'b1, 2'h3, 16'h0000);
    bus(1'b0, 2'h3, 16'h0000);
    chk(got, 16'h0000);
    bus(1'b0, 2'h0, 16'h0000);
    chk(got, 16'hc3ff);
    // Low lane only: the high byte keeps its value
    byteenable <= 4'h1;
    bus(1'b1, 2'h0, 16'h0000);
    byteenable <= 4'h3;
    bus(1'b0, 2'h0, 16'h0000);
    chk(got, 16'hc300);
    // Each source from a random start: own flag set, others kept
    for (int s = 0; s < 11; s++) begin
      exp_q = 16'($urandom) & 16'hc3ff;
      bus(1'b1, 2'h0, exp_q);
      k  = rst_cnt;
      r1 = cold_cnt;
      pulse(s);
      exp_q[bitpos[s]] = 1'b1;
      chk(rst_cnt > k, s != 7 && s != 8);
      chk(cold_cnt > r1, s == 9);
      bus(1'b0, 2'h0, 16'h0000);
      chk(got, exp_q);
      chk(got[bitpos[s]], 1'b1);
    end
    // Trap held through a clearing write: hardware set wins
    @(posedge clock);
    sel   <= 4'h3;
    level <= 1'b1;
    bus(1'b1, 2'h0, 16'h0000);
    level <= 1'b0;
    bus(1'b0, 2'h0, 16'h0000);
    chk(got, 16'h8000);
    // Fuse forces the watchdog on while the enable bit is clear
    watchdog_fuse_enable <= 1'b1;
    repeat (5) @(posedge clock);
    chk(watchdog_enable, 1'b1);
    watchdog_fuse_enable <= 1'b0;
    repeat (5) @(posedge clock);
    chk(watchdog_enable, 1'b0);
    // Clock enable low: a source pulse leaves flags and reset untouched
    k = rst_cnt;
    ce <= 1'b0;
    pulse(0);
    ce <= 1'b1;
    chk(rst_cnt, k);
    bus(1'b0, 2'h0, 16'h0000);
    chk(got, 16'h8000);
    conclude();
  end
endmodule : testbench
